// ### common/dpicd_pkg.sv
// Purpose: Shared constants for the PHY init sequencer and command delay
// Assumes: System clock mclk at 25 MHz
// Notes:   Wait counts are in system clocks
package dpicd_pkg;
    localparam int unsigned WAIT_W          = 18;
    localparam logic [17:0] WAIT_MAX        = 18'h3ffff;
    localparam logic [17:0] RESET_WAIT_DEF  = 18'h0d039;  // 53305 clocks
    localparam logic [17:0] CKE_WAIT_DEF    = 18'h2088f;  // 133263 clocks
    localparam int unsigned CMD_W           = 32;
    localparam int unsigned DLY_STAGES      = 2;
    localparam logic [1:0]  DLY_NONE        = 2'h0;
    localparam logic [1:0]  DLY_ONE         = 2'h1;
    localparam logic [1:0]  DLY_TWO         = 2'h2;
    localparam int unsigned NSTAGE          = 7;
    // Stage index in the calibration enable vector
    localparam int unsigned ST_WRLVL        = 0;
    localparam int unsigned ST_GATE         = 1;
    localparam int unsigned ST_RDTRAIN      = 2;
    localparam int unsigned ST_WRDQSDQ      = 3;
    localparam int unsigned ST_COMPLEX      = 4;
    localparam int unsigned ST_RDVREF       = 5;
    localparam int unsigned ST_WRVREF       = 6;

    typedef enum logic [2:0] {
        DPICD_WAIT_SELFCAL,
        DPICD_WAIT_RESET,
        DPICD_WAIT_CKE,
        DPICD_CALIBRATE,
        DPICD_DONE
    } dpicd_state_e;
endpackage : dpicd_pkg

// ### design/dpicd_cmd_pipe.sv
// Purpose: Bypassable zero to two stage command/address delay pipeline
// Assumes: Delay select is quasi-static during traffic
// Notes:   Same delay applied to every command bit; output is registered
`timescale 1ns/1ps
module dpicd_cmd_pipe
    import dpicd_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [1:0]       dly_sel,
    input  wire logic [CMD_W-1:0] cmd_in,
    output logic      [CMD_W-1:0] cmd_out_q
);
    logic [CMD_W-1:0] stage_q [DLY_STAGES];

    genvar g;
    generate
        for (g = 0; g < DLY_STAGES; g++) begin : g_stage
            if (g == 0) begin : g_first
                always_ff @(posedge mclk or negedge rst_n) begin
                    if (!rst_n) begin
                        stage_q[g] <= '0;
                    end else begin
                        stage_q[g] <= cmd_in;
                    end
                end
            end else begin : g_next
                always_ff @(posedge mclk or negedge rst_n) begin
                    if (!rst_n) begin
                        stage_q[g] <= '0;
                    end else begin
                        stage_q[g] <= stage_q[g-1];
                    end
                end
            end
        end
    endgenerate

    // Output register sits after the select so every setting pays the same one flop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_out_q <= '0;
        end else begin
            case (dly_sel)
                DLY_ONE: cmd_out_q <= stage_q[0];
                DLY_TWO: cmd_out_q <= stage_q[1];
                default: cmd_out_q <= cmd_in;
            endcase
        end
    end
endmodule : dpicd_cmd_pipe

// ### design/dpicd_top.sv
// Purpose: PHY power-up timing, calibration stage selection and command delay
// Assumes: All inputs except rstn and selfcal_done are on mclk
// Notes:   Calibration stages are reported as enables; the stage engines are outside
`timescale 1ns/1ps
module dpicd_top
    import dpicd_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              selfcal_done,
    input  wire logic              cal_bypass,
    input  wire logic              cal_complex_skip,
    input  wire logic              cal_rd_vref_full,
    input  wire logic              cal_wr_vref_full,
    input  wire logic              cal_jitter_reduced,
    input  wire logic              cal_stages_done,
    input  wire logic [WAIT_W-1:0] reset_release_wait,
    input  wire logic [WAIT_W-1:0] clock_enable_wait,
    input  wire logic [1:0]        command_path_added_delay,
    input  wire logic [CMD_W-1:0]  ctrl_cmd,
    input  wire logic              ctrl_write_column_strobe,
    input  wire logic              ctrl_read_column_strobe,
    output logic                   dram_reset_n_q,
    output logic                   dram_cke_q,
    output logic                   cal_run_q,
    output logic [NSTAGE-1:0]      cal_stage_en_q,
    output logic                   cal_jitter_full_q,
    output logic                   cal_done_q,
    output logic [CMD_W-1:0]       dram_cmd_q,
    output logic                   phy_write_strobe_q,
    output logic                   phy_read_strobe_q,
    output logic [1:0]             phy_extra_latency_q
);
    logic              rst_s1_q;
    logic              rst_n_q;
    logic              sc_s1_q;
    logic              sc_s2_q;
    dpicd_state_e      state_q;
    logic [WAIT_W-1:0] cnt_q;
    logic              reset_wait_over;
    logic              cke_wait_over;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Self-calibration done comes from the I/O bank, not from mclk logic
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sc_s1_q <= 1'b0;
            sc_s2_q <= 1'b0;
        end else begin
            sc_s1_q <= selfcal_done;
            sc_s2_q <= sc_s1_q;
        end
    end

    // Wait values are taken live; hold them steady during power-up
    // Saturating at the counter limit keeps an oversized wait from hanging the sequence
    assign reset_wait_over = (cnt_q >= reset_release_wait) || (cnt_q == WAIT_MAX);
    assign cke_wait_over   = (cnt_q >= clock_enable_wait) || (cnt_q == WAIT_MAX);

    // Power-up sequencer
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= DPICD_WAIT_SELFCAL;
        end else begin
            case (state_q)
                DPICD_WAIT_SELFCAL: begin
                    if (sc_s2_q) begin
                        state_q <= DPICD_WAIT_RESET;
                    end
                end
                DPICD_WAIT_RESET: begin
                    if (reset_wait_over) begin
                        state_q <= DPICD_WAIT_CKE;
                    end
                end
                DPICD_WAIT_CKE: begin
                    if (cke_wait_over) begin
                        state_q <= cal_bypass ? DPICD_DONE : DPICD_CALIBRATE;
                    end
                end
                DPICD_CALIBRATE: begin
                    if (cal_stages_done) begin
                        state_q <= DPICD_DONE;
                    end
                end
                DPICD_DONE: begin
                    state_q <= DPICD_DONE;
                end
                default: begin
                    state_q <= DPICD_WAIT_SELFCAL;
                end
            endcase
        end
    end

    // Wait counter, cleared as each wait ends so the next one starts from zero
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q <= '0;
        end else begin
            case (state_q)
                DPICD_WAIT_RESET: begin
                    cnt_q <= reset_wait_over ? '0 : cnt_q + 1'b1;
                end
                DPICD_WAIT_CKE: begin
                    cnt_q <= cke_wait_over ? '0 : cnt_q + 1'b1;
                end
                default: begin
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // DRAM reset pin, released once the reset wait is over
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dram_reset_n_q <= 1'b0;
        end else begin
            dram_reset_n_q <= (state_q != DPICD_WAIT_SELFCAL) && (state_q != DPICD_WAIT_RESET);
        end
    end

    // DRAM clock enable pin, raised once the clock enable wait is over
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dram_cke_q <= 1'b0;
        end else begin
            dram_cke_q <= (state_q == DPICD_CALIBRATE) || (state_q == DPICD_DONE);
        end
    end

    // Sequencer status flags
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cal_run_q  <= 1'b0;
            cal_done_q <= 1'b0;
        end else begin
            cal_run_q  <= (state_q == DPICD_CALIBRATE);
            cal_done_q <= (state_q == DPICD_DONE);
        end
    end

    // Stage enables; the first four stages have no skip option
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cal_stage_en_q <= '0;
        end else begin
            cal_stage_en_q[ST_WRLVL]   <= !cal_bypass;
            cal_stage_en_q[ST_GATE]    <= !cal_bypass;
            cal_stage_en_q[ST_RDTRAIN] <= !cal_bypass;
            cal_stage_en_q[ST_WRDQSDQ] <= !cal_bypass;
            cal_stage_en_q[ST_COMPLEX] <= !cal_bypass && !cal_complex_skip;
            cal_stage_en_q[ST_RDVREF]  <= !cal_bypass && cal_rd_vref_full;
            cal_stage_en_q[ST_WRVREF]  <= !cal_bypass && cal_wr_vref_full;
        end
    end

    // Jitter calibration mode
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cal_jitter_full_q <= 1'b1;
        end else begin
            // Reduced jitter search shortens simulation only; hardware must keep it low
            cal_jitter_full_q <= !cal_jitter_reduced;
        end
    end

    // Column strobes bypass the command delay so control logic gains lead time
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phy_write_strobe_q <= 1'b0;
            phy_read_strobe_q  <= 1'b0;
        end else begin
            phy_write_strobe_q <= ctrl_write_column_strobe;
            phy_read_strobe_q  <= ctrl_read_column_strobe;
        end
    end

    // Added delay reported as extra latency; setting 3 is not legal and counts as none
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            phy_extra_latency_q <= DLY_NONE;
        end else begin
            case (command_path_added_delay)
                DLY_ONE: phy_extra_latency_q <= DLY_ONE;
                DLY_TWO: phy_extra_latency_q <= DLY_TWO;
                default: phy_extra_latency_q <= DLY_NONE;
            endcase
        end
    end

    // Delay chosen by the integrator per rank, ECC and latencies
    dpicd_cmd_pipe u_cmd_pipe (
        .mclk      (mclk),
        .rst_n     (rst_n_q),
        .dly_sel   (command_path_added_delay),
        .cmd_in    (ctrl_cmd),
        .cmd_out_q (dram_cmd_q)
    );
endmodule : dpicd_top

// ### verification/dpicd_asserts.sv
// Purpose: Port checks for dpicd_top
// Assumes: Config inputs held steady between resets
// Notes:   rdy_q masks the two-flop reset release
`timescale 1ns/1ps
module dpicd_asserts
    import dpicd_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        selfcal_done,
    input wire logic        cal_complex_skip,
    input wire logic        cal_rd_vref_full,
    input wire logic        cal_wr_vref_full,
    input wire logic        cal_jitter_reduced,
    input wire logic [17:0] reset_release_wait,
    input wire logic [17:0] clock_enable_wait,
    input wire logic [1:0]  command_path_added_delay,
    input wire logic [31:0] ctrl_cmd,
    input wire logic        ctrl_write_column_strobe,
    input wire logic        ctrl_read_column_strobe,
    input wire logic        dram_reset_n_q,
    input wire logic        dram_cke_q,
    input wire logic        cal_run_q,
    input wire logic [6:0]  cal_stage_en_q,
    input wire logic        cal_jitter_full_q,
    input wire logic [31:0] dram_cmd_q,
    input wire logic        phy_write_strobe_q,
    input wire logic        phy_read_strobe_q,
    input wire logic [1:0]  phy_extra_latency_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [1:0]  rdy_q;
    logic [18:0] sc_q, rn_q;
    wire  [1:0]  d_eff = (command_path_added_delay == 2'h3) ? 2'h0 : command_path_added_delay;
    // sc_q and rn_q are plain counters: they wrap only after 2^19 clocks, far past any simulated wait; rdy_q stops at 3
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdy_q <= 2'h0;
            sc_q  <= 19'h0;
            rn_q  <= 19'h0;
        end else begin
            rdy_q <= rdy_q + {1'b0, rdy_q != 2'h3};
            sc_q  <= sc_q + {18'h0, selfcal_done};
            rn_q  <= rn_q + {18'h0, dram_reset_n_q};
        end
    end
    sequence s_quiet; (rdy_q == 2'h3 && $stable(command_path_added_delay)) [*3]; endsequence
    property p_cmd; s_quiet |-> dram_cmd_q == (d_eff == 2'h0 ? $past(ctrl_cmd) :
        d_eff == 2'h1 ? $past(ctrl_cmd, 2) : $past(ctrl_cmd, 3)); endproperty
    property p_strb; rdy_q == 2'h3 |=> {phy_write_strobe_q, phy_read_strobe_q} ==
        $past({ctrl_write_column_strobe, ctrl_read_column_strobe}); endproperty
    property p_lat; rdy_q == 2'h3 |=> phy_extra_latency_q == $past(d_eff); endproperty
    // Sync flops, entry cycle and output flop add about five clocks to the wait
    property p_rst; $rose(dram_reset_n_q) |->
        sc_q inside {[reset_release_wait + 18'h4 : reset_release_wait + 18'h6]}; endproperty
    property p_cke; $rose(dram_cke_q) |->
        rn_q inside {[clock_enable_wait : clock_enable_wait + 18'h4]}; endproperty
    property p_order; dram_cke_q |-> dram_reset_n_q; endproperty
    property p_stage; cal_run_q |-> cal_stage_en_q ==
        {cal_wr_vref_full, cal_rd_vref_full, !cal_complex_skip, 4'hf}; endproperty
    property p_jit; rdy_q == 2'h3 |-> cal_jitter_full_q == !cal_jitter_reduced; endproperty
    a_cmd: assert property (p_cmd) else $error("cmd delay wrong");
    a_strb: assert property (p_strb) else $error("strobe delayed");
    a_lat: assert property (p_lat) else $error("extra latency wrong");
    a_rst: assert property (p_rst) else $error("reset release time");
    a_cke: assert property (p_cke) else $error("cke time");
    a_order: assert property (p_order) else $error("cke before reset");
    a_stage: assert property (p_stage) else $error("stage enables");
    a_jit: assert property (p_jit) else $error("jitter mode");
endmodule : dpicd_asserts

// ### verification/dpicd_ctrl_model.sv
// Purpose: Random command traffic from a custom controller
// Assumes: Seed fixed for repeatable runs
// Notes:   Strobes are never both high in one cycle
`timescale 1ns/1ps
module dpicd_ctrl_model (
    input  wire logic        mclk,
    input  wire logic        go,
    output logic      [31:0] cmd = 32'h0,
    output logic             wr  = 1'b0,
    output logic             rd  = 1'b0
);
    int seed = 32'h8db3;
    // No check bits built here, so no early write request is needed
    always @(posedge mclk) begin
        cmd <= go ? $random(seed) : ~cmd;
        wr  <= go & seed[0];
        rd  <= go & ~seed[0] & seed[1];
    end
endmodule : dpicd_ctrl_model

// ### verification/testbench.sv
// Purpose: Self-checking bench for dpicd_top
// Assumes: Short wait counts of 5 and 7 clocks
// Notes:   Command path compared against a history queue
`timescale 1ns/1ps
module testbench;
    import dpicd_pkg::*;
    logic mclk, rstn, selfcal_done, cal_bypass, cal_complex_skip, cal_rd_vref_full, go;
    logic cal_wr_vref_full, cal_jitter_reduced, cal_stages_done, ctrl_write_column_strobe;
    logic ctrl_read_column_strobe, dram_reset_n_q, dram_cke_q, cal_run_q, cal_jitter_full_q;
    logic cal_done_q, phy_write_strobe_q, phy_read_strobe_q;
    logic [WAIT_W-1:0] reset_release_wait, clock_enable_wait;
    logic [1:0]        command_path_added_delay, phy_extra_latency_q;
    logic [NSTAGE-1:0] cal_stage_en_q;
    logic [CMD_W-1:0]  ctrl_cmd, dram_cmd_q;
    logic [CMD_W+1:0]  hist[$];
    int n_fail = 0, compares = 0, cyc;
    dpicd_top i_dut (
        .mclk(mclk), .rstn(rstn), .selfcal_done(selfcal_done), .cal_bypass(cal_bypass),
        .cal_complex_skip(cal_complex_skip), .cal_rd_vref_full(cal_rd_vref_full),
        .cal_wr_vref_full(cal_wr_vref_full), .cal_jitter_reduced(cal_jitter_reduced),
        .cal_stages_done(cal_stages_done), .reset_release_wait(reset_release_wait),
        .clock_enable_wait(clock_enable_wait),
        .command_path_added_delay(command_path_added_delay), .ctrl_cmd(ctrl_cmd),
        .ctrl_write_column_strobe(ctrl_write_column_strobe),
        .ctrl_read_column_strobe(ctrl_read_column_strobe),
        .dram_reset_n_q(dram_reset_n_q), .dram_cke_q(dram_cke_q), .cal_run_q(cal_run_q),
        .cal_stage_en_q(cal_stage_en_q), .cal_jitter_full_q(cal_jitter_full_q),
        .cal_done_q(cal_done_q), .dram_cmd_q(dram_cmd_q),
        .phy_write_strobe_q(phy_write_strobe_q), .phy_read_strobe_q(phy_read_strobe_q),
        .phy_extra_latency_q(phy_extra_latency_q)
    );
    dpicd_ctrl_model i_ctrl (.mclk(mclk), .go(go), .cmd(ctrl_cmd),
        .wr(ctrl_write_column_strobe), .rd(ctrl_read_column_strobe));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic cmp(input logic [CMD_W-1:0] got, input logic [CMD_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_range(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("BAD %0t wait %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : cmp_range
    task automatic tally_and_finish();
        $display("n_fail=%0d compares=%0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    // opt is {wr vref, rd vref, complex skip, jitter reduced}
    task automatic power_up(input logic byp, input logic [3:0] opt);
        @(posedge mclk);
        rstn <= 1'b0;
        {selfcal_done, cal_stages_done, go} <= 3'h0;
        {cal_bypass, cal_wr_vref_full, cal_rd_vref_full, cal_complex_skip} <= {byp, opt[3:1]};
        cal_jitter_reduced <= opt[0];
        command_path_added_delay <= DLY_NONE;
        reset_release_wait <= 18'h5;
        clock_enable_wait <= 18'h7;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        selfcal_done <= 1'b1;
        #1;
        // Two sync flops, the entry cycle and the output flop come on top of the count
        for (cyc = 0; cyc < 99 && dram_reset_n_q !== 1'b1; cyc++) begin
            @(posedge mclk);
            #1;
        end
        cmp_range(cyc, 8, 12);
        for (cyc = 0; cyc < 99 && dram_cke_q !== 1'b1; cyc++) begin
            @(posedge mclk);
            #1;
        end
        cmp_range(cyc, 7, 11);
        repeat (2) @(posedge mclk);
        #1;
        cmp(cal_run_q, !byp);
        cmp(cal_stage_en_q, byp ? 7'h0 : {opt[3:2], !opt[1], 4'hf});
        cmp(cal_jitter_full_q, !opt[0]);
        @(posedge mclk);
        cal_stages_done <= 1'b1;
        #1;
        for (cyc = 0; cyc < 20 && cal_done_q !== 1'b1; cyc++) begin
            @(posedge mclk);
            #1;
        end
        #1;
        cmp({cal_done_q, cal_run_q}, 2'h2);
    endtask : power_up
    initial begin
        power_up(1'b0, 4'b1010);
        // Delays 1 and 2 suit low write latency setups; 3 must act as none
        for (int d = 0; d < 4; d++) begin
            for (int k = 0; k < 16; k++) begin
                @(posedge mclk);
                if (k == 0) command_path_added_delay <= d[1:0];
                go <= 1'b1;
                hist.push_front({ctrl_write_column_strobe, ctrl_read_column_strobe, ctrl_cmd});
                #1;
                if (k > 3) begin
                    cmp(dram_cmd_q, hist[(d == 3) ? 0 : d][CMD_W-1:0]);
                    cmp({phy_write_strobe_q, phy_read_strobe_q}, hist[0][CMD_W+1:CMD_W]);
                    cmp(phy_extra_latency_q, (d == 3) ? 2'h0 : d[1:0]);
                end
            end
        end
        power_up(1'b1, 4'b0101);
        tally_and_finish();
    end
    initial begin
        #100us;
        n_fail++;
        tally_and_finish();
    end
endmodule : testbench
bind dpicd_top dpicd_asserts i_chk (
    .mclk(mclk), .rstn(rstn), .selfcal_done(selfcal_done),
    .cal_complex_skip(cal_complex_skip), .cal_rd_vref_full(cal_rd_vref_full),
    .cal_wr_vref_full(cal_wr_vref_full), .cal_jitter_reduced(cal_jitter_reduced),
    .reset_release_wait(reset_release_wait), .clock_enable_wait(clock_enable_wait),
    .command_path_added_delay(command_path_added_delay), .ctrl_cmd(ctrl_cmd),
    .ctrl_write_column_strobe(ctrl_write_column_strobe),
    .ctrl_read_column_strobe(ctrl_read_column_strobe),
    .dram_reset_n_q(dram_reset_n_q), .dram_cke_q(dram_cke_q), .cal_run_q(cal_run_q),
    .cal_stage_en_q(cal_stage_en_q), .cal_jitter_full_q(cal_jitter_full_q),
    .dram_cmd_q(dram_cmd_q), .phy_write_strobe_q(phy_write_strobe_q),
    .phy_read_strobe_q(phy_read_strobe_q), .phy_extra_latency_q(phy_extra_latency_q)
);
